//--- rtl/pidec_pkg.sv
// Operation
// [R1] Process-cache descriptor needs 256-bit queue, else error
// [R2] Process-cache granularity: domain, process-in-domain, all
// [R3] Coarser invalidation allowed, never narrower
// [R4] Domain bits above implemented width ignored
// [R5] Process id ignored for all-process granularities
// [R6] Flush write buffers before process-cache invalidation
// [R7] Software follows with matching translation-cache invalidation
// [R8] Translation descriptor 128 bits; width mismatch errors
// [R9] Translation global: invalidate all entries
// [R10] Translation domain: invalidate by domain tag
// [R11] Page: second-level tlb needs domain and address
// [R12] Page: second-level walk cache kept when hint
// [R13] Hint ignored for global and domain granularities
// [R14] Read-drain flag drains reads before next wait
// [R15] Write-drain flag drains writes before next wait
// [R16] Domain field ignored for global translation invalidation
// [R17] Address high bits ignored; address unused unless page
// [R18] Software encodes page-count exponent 0, 9, 18
// [R19] Flush write buffers before translation-cache invalidation
// [R20] Software fills domain from process-table entry
// [R21] Type taken from bits 11:9 and 3:0
// [R22] Undefined granularity codes raise descriptor error
package pidec_pkg;

    // Register byte offsets
    localparam logic [7:0]  CTRL_OFS     = 8'h00;
    localparam logic [7:0]  STATUS_OFS   = 8'h04;
    localparam logic [7:0]  SUBMIT_OFS   = 8'h08;
    localparam logic [7:0]  DESC_OFS     = 8'h20;   // Eight words, 0x20..0x3C
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

    // Register bit positions
    localparam int CTRL_QW_BIT   = 0;   // Queue holds 256-bit descriptors
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ERR_BIT  = 1;   // Sticky, write one to clear
    localparam int STAT_DRD_BIT  = 2;   // Read drain pending
    localparam int STAT_DWR_BIT  = 3;   // Write drain pending

    // Descriptor type codes, {bits 11:9, bits 3:0}
    localparam logic [6:0] TYPE_TLB = 7'h02;
    localparam logic [6:0] TYPE_PC  = 7'h07;

    // Granularity codes
    localparam logic [1:0] PC_G_DOMAIN  = 2'h0;
    localparam logic [1:0] PC_G_PASID   = 2'h1;
    localparam logic [1:0] PC_G_ALL     = 2'h3;
    localparam logic [1:0] TLB_G_ALL    = 2'h1;
    localparam logic [1:0] TLB_G_DOMAIN = 2'h2;
    localparam logic [1:0] TLB_G_PAGE   = 2'h3;

    // Descriptor field positions and widths
    localparam int G_LSB       = 4;
    localparam int WRDRAIN_BIT = 6;
    localparam int RDDRAIN_BIT = 7;
    localparam int DOM_LSB     = 16;
    localparam int DOM_W       = 16;
    localparam int PASID_LSB   = 32;
    localparam int PASID_W     = 20;
    localparam int PGEXP_LSB   = 64;
    localparam int PGEXP_W     = 6;
    localparam int HINT_BIT    = 70;
    localparam int ADDR_LSB    = 76;
    localparam int ADDR_W      = 52;   // Page address bits 63:12
    localparam int PAGE_SHIFT  = 12;

    typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_FLUSH, ST_ISSUE} pidec_state_type;
    typedef enum logic [1:0] {PC_SCOPE_DOMAIN, PC_SCOPE_PASID, PC_SCOPE_ALL} pidec_scope_type;

    // Process-context cache command
    typedef struct packed {
        pidec_scope_type    scope;
        logic [DOM_W-1:0]   domain;
        logic [PASID_W-1:0] pasid;
    } pidec_pc_cmd_type;

    // Translation and paging-structure cache command
    typedef struct packed {
        logic               matchAll;      // Every entry, tags ignored
        logic               slTlbUseAddr;  // Second-level tlb entries also match address
        logic               slPscInval;    // Second-level walk entries invalidated
        logic [DOM_W-1:0]   domain;
        logic [ADDR_W-1:0]  addr;
        logic [PGEXP_W-1:0] pageExp;       // Page-count exponent
    } pidec_tlb_cmd_type;

    // Decoder result
    typedef struct packed {
        logic              isPc;
        logic              isTlb;
        logic              bad;
        logic              drainRd;
        logic              drainWr;
        pidec_pc_cmd_type  pc;
        pidec_tlb_cmd_type tlb;
    } pidec_dec_type;

endpackage

//--- rtl/pidec_decode.sv
// Combinational decode of one fetched descriptor
module pidec_decode #(
    parameter int DOMAIN_BITS = 16,
    parameter int GADDR_BITS  = 48
) (
    // Descriptor and queue setup
    input  wire logic [255:0]           desc,
    input  wire logic                   queueWide,
    // Decoded command
    output pidec_pkg::pidec_dec_type    dec
);
    import pidec_pkg::*;

    logic [6:0]        descType;   // Split type field
    logic [1:0]        gran;       // Requested granularity
    logic [DOM_W-1:0]  domMasked;  // Domain with unimplemented bits cleared
    logic [ADDR_W-1:0] addrMasked; // Page address above guest width cleared

    assign descType = {desc[11:9], desc[3:0]};  // R21
    assign gran     = desc[G_LSB +: 2];

    // Field masking; domain used by both descriptor kinds, address by page translation only
    always_comb begin
        for (int i = 0; i < DOM_W; i++) begin
            domMasked[i] = (i < DOMAIN_BITS) ? desc[DOM_LSB + i] : 1'b0;  // R4
        end
        for (int i = 0; i < ADDR_W; i++) begin
            addrMasked[i] = (i + PAGE_SHIFT < GADDR_BITS) ? desc[ADDR_LSB + i] : 1'b0;  // R17
        end
    end

    // Type, width and granularity decode
    always_comb begin
        dec = '0;
        // Widest scope by default: coarser is legal, narrower never
        dec.pc.scope = PC_SCOPE_ALL;  // R3
        dec.tlb.matchAll = 1'b1;
        dec.tlb.slPscInval = 1'b1;
        if (descType == TYPE_PC) begin
            dec.isPc = 1'b1;
            dec.bad = !queueWide;  // R1
            dec.pc.domain = domMasked;
            case (gran)
                PC_G_DOMAIN: begin
                    dec.pc.scope = PC_SCOPE_DOMAIN;  // R2 R5
                end
                PC_G_PASID: begin
                    dec.pc.scope = PC_SCOPE_PASID;  // R2
                    dec.pc.pasid = desc[PASID_LSB +: PASID_W];
                end
                PC_G_ALL: begin
                    dec.pc.scope = PC_SCOPE_ALL;  // R2 R5
                    dec.pc.domain = '0;
                end
                default: begin
                    dec.bad = 1'b1;  // R22
                end
            endcase
        end else if (descType == TYPE_TLB) begin
            dec.isTlb = 1'b1;
            // Zero upper half is the only legal form in a wide queue
            dec.bad = queueWide && (desc[255:128] != '0);  // R8
            dec.drainRd = desc[RDDRAIN_BIT];
            dec.drainWr = desc[WRDRAIN_BIT];
            case (gran)
                TLB_G_ALL: begin
                    dec.tlb.matchAll = 1'b1;  // R9 R16 R13
                end
                TLB_G_DOMAIN: begin
                    dec.tlb.matchAll = 1'b0;  // R10 R13
                    dec.tlb.domain = domMasked;
                end
                TLB_G_PAGE: begin
                    dec.tlb.matchAll = 1'b0;  // R11
                    dec.tlb.domain = domMasked;
                    dec.tlb.slTlbUseAddr = 1'b1;
                    dec.tlb.slPscInval = !desc[HINT_BIT];  // R12
                    dec.tlb.addr = addrMasked;
                    dec.tlb.pageExp = desc[PGEXP_LSB +: PGEXP_W];
                end
                default: begin
                    dec.bad = 1'b1;  // R22
                end
            endcase
        end else begin
            dec.bad = 1'b1;  // Unsupported type
        end
    end

endmodule

//--- rtl/pidec_engine.sv
// Invalidation engine: register slave, sequencing, cache commands
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
module pidec_engine #(
    parameter int   DOMAIN_BITS = 16,
    parameter int   GADDR_BITS  = 48,
    parameter logic WBUF_FLUSH  = 1'b1   // Write-buffer flush required
) (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst_b,
    // AHB-Lite slave
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    // Write-buffer flush handshake
    output logic                               wbFlushReq,
    input  wire logic                          wbFlushAck,
    // Process-context cache command
    output logic                               pcValid,
    output pidec_pkg::pidec_pc_cmd_type        pcCmd,
    // Translation cache command
    output logic                               tlbValid,
    output pidec_pkg::pidec_tlb_cmd_type       tlbCmd,
    // Shared command acceptance
    input  wire logic                          cmdReady,
    // Drain requests toward the wait logic
    output logic                               drainRdPending,
    output logic                               drainWrPending,
    input  wire logic                          drainDone
);
    import pidec_pkg::*;

    // Bus data-phase state
    logic                    wrPend, next_wrPend;        // Write data due this cycle
    logic [7:0]              wrAddr, next_wrAddr;        // Latched write offset
    logic [31:0]             next_hrdata;
    // Software-visible state
    logic [31:0]             ctrl, next_ctrl;            // Queue width setup
    logic [7:0][31:0]        descWord, next_descWord;    // Staged descriptor
    logic                    errFlag, next_errFlag;      // Sticky descriptor error
    logic                    drainRd, next_drainRd;
    logic                    drainWr, next_drainWr;
    // Sequencer state
    pidec_state_type         state, next_state;
    pidec_dec_type           cur, next_cur;              // Latched decode
    pidec_dec_type           dec;                        // Live decode
    logic                    flushSeen, next_flushSeen;  // Flush done for this descriptor

    logic                    addrPhase;                  // Valid address phase
    logic                    submitWr;                   // Write to submit register
    logic                    errClr;                     // Write one to error bit
    logic                    issueDone;                  // Command accepted

    // Descriptor decoder
    pidec_decode #(
        .DOMAIN_BITS (DOMAIN_BITS),
        .GADDR_BITS  (GADDR_BITS)
    ) u_decode (
        .desc      (descWord),
        .queueWide (ctrl[CTRL_QW_BIT]),
        .dec       (dec)
    );

    // Slave never stretches, always answers OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign addrPhase = hsel && htrans[1] && hready;
    assign submitWr  = wrPend && (wrAddr == SUBMIT_OFS);
    assign errClr    = wrPend && (wrAddr == STATUS_OFS) && hwdata[STAT_ERR_BIT];

    // Handshake outputs follow the sequencer state
    assign pcValid    = (state == ST_ISSUE) && cur.isPc;
    assign tlbValid   = (state == ST_ISSUE) && cur.isTlb;
    assign wbFlushReq = (state == ST_FLUSH);
    assign issueDone  = (state == ST_ISSUE) && cmdReady;
    assign pcCmd      = cur.pc;
    assign tlbCmd     = cur.tlb;
    assign drainRdPending = drainRd;
    assign drainWrPending = drainWr;

    // Register read mux, word aligned
    function automatic logic [31:0] readWord(input logic [7:0] ofs);
        logic [31:0] val;
        val = 32'h0000_0000;
        if (ofs == CTRL_OFS) begin
            val = ctrl;
        end else if (ofs == STATUS_OFS) begin
            val[STAT_BUSY_BIT] = (state != ST_IDLE);
            val[STAT_ERR_BIT]  = errFlag;
            val[STAT_DRD_BIT]  = drainRd;
            val[STAT_DWR_BIT]  = drainWr;
        end else if (ofs >= DESC_OFS && ofs < DESC_OFS + 8'h20) begin
            val = descWord[ofs[4:2]];
        end
        return val;
    endfunction

    // Bus and register next values
    always_comb begin
        next_wrPend   = addrPhase && hwrite;
        next_wrAddr   = addrPhase ? {haddr[7:2], 2'b00} : wrAddr;
        next_hrdata   = (addrPhase && !hwrite) ? readWord({haddr[7:2], 2'b00}) : hrdata;
        next_ctrl     = ctrl;
        next_descWord = descWord;
        if (wrPend) begin
            if (wrAddr == CTRL_OFS) begin
                next_ctrl = {31'h0000_0000, hwdata[CTRL_QW_BIT]};
            end else if (wrAddr >= DESC_OFS && wrAddr < DESC_OFS + 8'h20 &&
                         state == ST_IDLE) begin
                // Staged words are frozen while a descriptor is in flight
                next_descWord[wrAddr[4:2]] = hwdata;
            end
        end
    end

    // Sequencer next values
    always_comb begin
        next_state     = state;
        next_cur       = cur;
        next_flushSeen = flushSeen;
        next_errFlag   = errFlag && !errClr;
        next_drainRd   = drainRd && !drainDone;
        next_drainWr   = drainWr && !drainDone;
        case (state)
            ST_IDLE: begin
                // Submits while busy are dropped; software polls busy
                if (submitWr) begin
                    next_state = ST_DECODE;
                    next_flushSeen = 1'b0;
                end
            end
            ST_DECODE: begin
                next_cur = dec;
                if (dec.bad) begin
                    next_errFlag = 1'b1;  // R1 R8 R22
                    next_state   = ST_IDLE;
                end else if (WBUF_FLUSH) begin
                    next_state = ST_FLUSH;  // R6 R19
                end else begin
                    next_state = ST_ISSUE;
                end
            end
            ST_FLUSH: begin
                if (wbFlushAck) begin
                    next_flushSeen = 1'b1;  // R6 R19
                    next_state = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (cmdReady) begin
                    // New drain request wins over a same-cycle completion
                    if (cur.isTlb && cur.drainRd) begin
                        next_drainRd = 1'b1;  // R14
                    end
                    if (cur.isTlb && cur.drainWr) begin
                        next_drainWr = 1'b1;  // R15
                    end
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Register all state
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend    <= 1'b0;
            wrAddr    <= 8'h00;
            hrdata    <= 32'h0000_0000;
            ctrl      <= CTRL_RESET;
            descWord  <= '0;
            errFlag   <= 1'b0;
            drainRd   <= 1'b0;
            drainWr   <= 1'b0;
            state     <= ST_IDLE;
            cur       <= '0;
            flushSeen <= 1'b0;
        end else begin
            wrPend    <= next_wrPend;
            wrAddr    <= next_wrAddr;
            hrdata    <= next_hrdata;
            ctrl      <= next_ctrl;
            descWord  <= next_descWord;
            errFlag   <= next_errFlag;
            drainRd   <= next_drainRd;
            drainWr   <= next_drainWr;
            state     <= next_state;
            cur       <= next_cur;
            flushSeen <= next_flushSeen;
        end
    end

    // Checks on the sequencer and the issued commands
    property p_pcWidth;
        @(posedge core_clk) disable iff (!rst_b)
        (state == ST_DECODE && dec.isPc && !ctrl[CTRL_QW_BIT]) |=> errFlag && state == ST_IDLE;
    endproperty
    a_pcWidth: assert property (p_pcWidth) else $error("narrow queue process descriptor accepted"); // R1

    property p_badNoIssue;
        @(posedge core_clk) disable iff (!rst_b)
        (state == ST_DECODE && dec.bad) |=> (!pcValid && !tlbValid) [*2];
    endproperty
    a_badNoIssue: assert property (p_badNoIssue) else $error("bad descriptor was issued"); // R22

    property p_flushFirst;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(pcValid || tlbValid) |-> (flushSeen || !WBUF_FLUSH);
    endproperty
    a_flushFirst: assert property (p_flushFirst) else $error("issued before flush"); // R6 R19

    property p_pcAllProc;
        @(posedge core_clk) disable iff (!rst_b)
        pcValid && pcCmd.scope != PC_SCOPE_PASID |-> pcCmd.pasid == '0;
    endproperty
    a_pcAllProc: assert property (p_pcAllProc) else $error("process id used for wide scope"); // R5

    property p_globalTags;
        @(posedge core_clk) disable iff (!rst_b)
        tlbValid && tlbCmd.matchAll |-> tlbCmd.domain == '0 && tlbCmd.addr == '0
            && tlbCmd.slPscInval;
    endproperty
    a_globalTags: assert property (p_globalTags) else $error("global command carries tags"); // R16

    property p_hintPage;
        @(posedge core_clk) disable iff (!rst_b)
        tlbValid && !tlbCmd.slTlbUseAddr |-> tlbCmd.slPscInval && tlbCmd.addr == '0;
    endproperty
    a_hintPage: assert property (p_hintPage) else $error("hint honoured outside page scope"); // R13

    property p_domainMask;
        @(posedge core_clk) disable iff (!rst_b)
        (pcValid || tlbValid) |-> ((pcCmd.domain | tlbCmd.domain) >> DOMAIN_BITS) == '0;
    endproperty
    a_domainMask: assert property (p_domainMask) else $error("unimplemented domain bit used"); // R4

    property p_drainRead;
        @(posedge core_clk) disable iff (!rst_b)
        (issueDone && tlbValid && cur.drainRd) |=> drainRdPending;
    endproperty
    a_drainRead: assert property (p_drainRead) else $error("read drain not recorded"); // R14

    property p_drainWrite;
        @(posedge core_clk) disable iff (!rst_b)
        (issueDone && tlbValid && cur.drainWr) |=> drainWrPending;
    endproperty
    a_drainWrite: assert property (p_drainWrite) else $error("write drain not recorded"); // R15

    property p_submitFlow;
        @(posedge core_clk) disable iff (!rst_b)
        (state == ST_IDLE && submitWr) |=> state == ST_DECODE ##1 state != ST_DECODE;
    endproperty
    a_submitFlow: assert property (p_submitFlow) else $error("submit did not decode once");

    c_pcIssue:   cover property (@(posedge core_clk) disable iff (!rst_b) pcValid && cmdReady);
    c_pageHint:  cover property (@(posedge core_clk) disable iff (!rst_b)
        tlbValid && tlbCmd.slTlbUseAddr && !tlbCmd.slPscInval);
    c_badDesc:   cover property (@(posedge core_clk) disable iff (!rst_b)
        state == ST_DECODE && dec.bad);
    c_drainBoth: cover property (@(posedge core_clk) disable iff (!rst_b)
        drainRd && drainWr);

endmodule

//--- testbench/test_pasid_and_iotlb_invalidation_decode.sv
module test_pasid_and_iotlb_invalidation_decode;
    timeunit 1ns;
    timeprecision 1ps;
    import pidec_pkg::*;

    // Narrow widths so that the ignored high bits really get exercised
    localparam int          DB    = 8;
    localparam int          MG    = 40;
    localparam logic [15:0] DMASK = 16'h00FF;
    localparam logic [51:0] AMASK = 52'h0_0000_0FFF_FFFF;
    localparam logic [15:0] DOM   = 16'hA5C3;
    localparam logic [19:0] PAS   = 20'h9ABCD;
    localparam logic [51:0] ADR   = 52'hABCDE_1234_5678;

    logic              core_clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0]       haddr, hwdata, hrdata;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic              wbFlushReq, wbFlushAck, pcValid, tlbValid, cmdReady;
    logic              drainRdPending, drainWrPending, drainDone;
    pidec_pc_cmd_type  pcCmd;
    pidec_tlb_cmd_type tlbCmd;
    int                errors, n_compared;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    pidec_engine #(.DOMAIN_BITS(DB), .GADDR_BITS(MG), .WBUF_FLUSH(1'b1)) dut (
        .core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .wbFlushReq, .wbFlushAck, .pcValid, .pcCmd,
        .tlbValid, .tlbCmd, .cmdReady, .drainRdPending, .drainWrPending, .drainDone);

    // Free-running clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic stop_test();
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkPc(input pidec_pc_cmd_type got, input pidec_pc_cmd_type exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t process command %h expected %h", $time, got, exp);
        end
    endtask

    // Mask leaves out command bits that the scope leaves free
    task automatic chkTlb(input pidec_tlb_cmd_type got, exp, msk);
        n_compared++;
        if ((got & msk) !== (exp & msk)) begin
            errors++;
            $display("BAD %0t translation command %h expected %h", $time, got, exp);
        end
    endtask

    // Ready is always sampled at a rising edge; the watchdog bounds it
    task automatic waitRdy();
        do @(posedge core_clk); while (hready !== 1'b1);
    endtask

    task automatic ahbW(input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b1;
        waitRdy();
        htrans <= 2'h0; hwdata <= d;
        waitRdy();
    endtask

    task automatic ahbR(input logic [31:0] a, output logic [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b0;
        waitRdy();
        htrans <= 2'h0;
        waitRdy();
        d = hrdata;
        chkVal({31'h0, hresp}, 32'h0);
    endtask

    function automatic logic [255:0] mk(input logic [6:0] t, input logic [1:0] g,
                                        input logic rf, wf, hint, input logic [5:0] px);
        logic [255:0] d;
        d = '0;
        d[3:0] = t[3:0];
        d[11:9] = t[6:4];
        d[G_LSB+:2] = g;
        d[WRDRAIN_BIT] = wf;
        d[RDDRAIN_BIT] = rf;
        d[DOM_LSB+:DOM_W] = DOM;
        d[PASID_LSB+:PASID_W] = PAS;
        d[PGEXP_LSB+:PGEXP_W] = px;
        d[HINT_BIT] = hint;
        d[ADDR_LSB+:ADDR_W] = ADR;
        return d;
    endfunction

    // Load all eight descriptor words, then kick the engine
    task automatic send(input logic [255:0] d);
        for (int k = 0; k < 8; k++) ahbW({24'h0, DESC_OFS} + 32'(4 * k), d[32*k+:32]);
        ahbW({24'h0, SUBMIT_OFS}, 32'h1);
    endtask

    // Rejected descriptor: nothing leaves, sticky error set, then cleared
    task automatic badDesc(input logic [255:0] d);
        logic [31:0] v;
        send(d);
        repeat (4) begin
            @(posedge core_clk);
            chkVal({29'h0, pcValid, tlbValid, wbFlushReq}, 32'h0);
        end
        ahbR({24'h0, STATUS_OFS}, v);
        chkVal(v & 32'h3, 32'h2);
        ahbW({24'h0, STATUS_OFS}, 32'h2);
        ahbR({24'h0, STATUS_OFS}, v);
        chkVal(v & 32'h3, 32'h0);
    endtask

    // Flush handshake first, then the command, then idle again
    task automatic issue(input logic isPc, input pidec_pc_cmd_type pe,
                         input pidec_tlb_cmd_type te, tm, input logic [31:0] st);
        int          n;
        logic [31:0] v;
        n = 0;
        do begin @(posedge core_clk); n++; end while (wbFlushReq !== 1'b1 && n < 20);
        chkVal({30'h0, pcValid, tlbValid}, 32'h0);
        chkVal({31'h0, wbFlushReq}, 32'h1);
        ahbR({24'h0, STATUS_OFS}, v);
        chkVal(v & 32'h1, 32'h1);
        wbFlushAck <= 1'b1;
        @(posedge core_clk);
        wbFlushAck <= 1'b0;
        n = 0;
        do begin @(posedge core_clk); n++; end
        while (pcValid !== 1'b1 && tlbValid !== 1'b1 && n < 20);
        chkVal({30'h0, pcValid, tlbValid}, isPc ? 32'h2 : 32'h1);
        if (isPc) chkPc(pcCmd, pe);
        else chkTlb(tlbCmd, te, tm);
        cmdReady <= 1'b1;
        @(posedge core_clk);
        cmdReady <= 1'b0;
        ahbR({24'h0, STATUS_OFS}, v);
        chkVal(v & 32'hF, st);
        chkVal({30'h0, drainWrPending, drainRdPending}, {30'h0, st[3:2]});
        drainDone <= 1'b1;
        @(posedge core_clk);
        drainDone <= 1'b0;
        ahbR({24'h0, STATUS_OFS}, v);
        chkVal(v & 32'hF, 32'h0);
    endtask

    task automatic regs();
        logic [31:0] v;
        ahbR({24'h0, CTRL_OFS}, v);
        chkVal(v, CTRL_RESET);
        ahbR(32'h10, v);
        chkVal(v, 32'h0);
        ahbW({24'h0, CTRL_OFS}, 32'h1);
        ahbR({24'h0, CTRL_OFS}, v);
        chkVal(v, 32'h1);
    endtask

    task automatic pcScopes();
        logic [1:0]       gs[3] = '{PC_G_DOMAIN, PC_G_PASID, PC_G_ALL};
        pidec_pc_cmd_type e;
        for (int i = 0; i < 3; i++) begin
            e.scope = pidec_scope_type'(i);
            e.domain = (i == 2) ? 16'h0 : (DOM & DMASK);
            e.pasid = (i == 1) ? PAS : 20'h0;
            send(mk(TYPE_PC, gs[i], 1'b0, 1'b0, 1'b0, 6'h0));
            issue(1'b1, e, '0, '0, 32'h0);
        end
    endtask

    task automatic tlbPage(input logic hint, rf, wf);
        pidec_tlb_cmd_type e;
        e = '{1'b0, 1'b1, ~hint, DOM & DMASK, ADR & AMASK, 6'h12};
        send(mk(TYPE_TLB, TLB_G_PAGE, rf, wf, hint, 6'h12));
        issue(1'b0, '0, e, '1, {28'h0, wf, rf, 2'h0});
    endtask

    task automatic tlbDomain(input logic [127:0] hi);
        pidec_tlb_cmd_type e;
        e = '{1'b0, 1'b0, 1'b1, DOM & DMASK, 52'h0, 6'h0};
        send({hi, 128'h0} | mk(TYPE_TLB, TLB_G_DOMAIN, 1'b0, 1'b0, 1'b1, 6'h9));
        issue(1'b0, '0, e, '{1'b1, 1'b1, 1'b1, 16'hFFFF, '1, 6'h0}, 32'h0);
    endtask

    task automatic tlbGlobal();
        pidec_tlb_cmd_type e;
        e = '{1'b1, 1'b0, 1'b0, 16'h0, 52'h0, 6'h0};
        send(mk(TYPE_TLB, TLB_G_ALL, 1'b0, 1'b0, 1'b1, 6'h9));
        issue(1'b0, '0, e, '{1'b1, 1'b0, 1'b0, 16'hFFFF, '1, 6'h0}, 32'h0);
    endtask

    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #100us;
        errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        errors = 0; n_compared = 0; rst_b = 1'b0;
        hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
        hwdata = '0; wbFlushAck = 1'b0; cmdReady = 1'b0; drainDone = 1'b0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        regs();
        pcScopes();
        tlbGlobal();
        badDesc(mk(TYPE_PC, 2'h2, 1'b0, 1'b0, 1'b0, 6'h0));
        badDesc({128'h1, 128'h0} | mk(TYPE_TLB, TLB_G_ALL, 1'b0, 1'b0, 1'b0, 6'h0));
        tlbPage(1'b0, 1'b1, 1'b1);
        ahbW({24'h0, CTRL_OFS}, 32'h0);
        badDesc(mk(TYPE_PC, PC_G_PASID, 1'b0, 1'b0, 1'b0, 6'h0));
        tlbDomain(128'hDEAD_BEEF_0000_1111_2222_3333_4444_5555);
        tlbPage(1'b1, 1'b1, 1'b0);
        badDesc(mk(TYPE_TLB, 2'h0, 1'b0, 1'b0, 1'b0, 6'h0));
        badDesc(mk(7'h12, TLB_G_ALL, 1'b0, 1'b0, 1'b0, 6'h0));
        stop_test();
    end
endmodule
